// ---- hw/sft_pkg.sv ----
// Purpose: Constants, opcodes and link codes for the parameter table block
// Assumes: 250 MHz core clock, serial link sampled by the core clock
// Notes:   The table image lives in the core, beside the parameters it reads
//
// Behaviour
// (RL1) Read: opcode, three address, one dummy, stream
// (RL2) Parameter read only in 1-1-1, 2-2-2, 4-4-4
// (RL3) Header count 01h at 06h, rev 01.00
// (RL4) First header: ID 00h, length 09h, pointer 30h
// (RL5) Vendor header: length 04h, pointer 60h
// (RL6) Byte 30h E5h, byte 31h 20h
// (RL7) Byte 32h reads B0h
// (RL8) Bytes 38h/39h read 44h and EBh
// (RL9) Bytes 3Eh/3Fh read 04h and BBh
// (RL10) Byte 40h FEh; 4Ah 44h, 4Bh EBh
// (RL11) Sector types size then opcode, fourth empty
// (RL12) Unused and unsupported bytes read FFh
// (RL13) Supply bytes 60h-63h: 00h,20h,50h,16h
// (RL14) Bytes 64h-65h form F99Ch
// (RL15) Wrap read: C0h at 66h, 64h at 67h
// (RL16) Bytes 68h-69h form C8D9h
// (RL17) Power-up: standby, write permit latch cleared
// (RL18) Below lockout: logic reset, commands ignored
// (RL19) Write commands only after both delays
// (RL20) Reads accepted after settle delay alone
// (RL21) Table address advances after every byte

package sft_pkg;

	// Core clock and power timing (times in ns)
	localparam int CLK_MHZ                   = 250;
	localparam int SUPPLY_SETTLE_DELAY_NS    = 800_000;
	localparam int WRITE_ACCESS_DELAY_NS     = 1_000_000;
	localparam int SETTLE_CYC                = (SUPPLY_SETTLE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int WRITE_ACCESS_CYC          = (WRITE_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000;

	// Wishbone register byte addresses
	localparam logic [3:0] REG_CTRL_ADR      = 4'h0;
	localparam logic [3:0] REG_STATUS_ADR    = 4'h4;
	localparam logic [3:0] REG_TADDR_ADR     = 4'h8;

	// Control and status field positions
	localparam int CTRL_WIDTH_LSB            = 0;
	localparam int ST_ABOVE_LOCKOUT          = 0;
	localparam int ST_READS_OK               = 1;
	localparam int ST_WRITES_OK              = 2;
	localparam int ST_WRITE_PERMIT           = 3;
	localparam int ST_DEEP_PD                = 4;
	localparam int ST_REFUSED                = 5;

	// Link widths
	typedef enum logic [1:0] {
		SFT_W1 = 2'b00,
		SFT_W2 = 2'b01,
		SFT_W4 = 2'b10
	} sft_width_t;
	localparam logic [1:0] CTRL_WIDTH_RST    = 2'b00;

	// Opcodes
	localparam logic [7:0] OP_PARAM_READ     = 8'h5A;
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OP_DEEP_PD        = 8'hB9;
	localparam logic [7:0] OP_RELEASE_PD     = 8'hAB;

	// Bit counts of the read frame
	localparam logic [5:0] OPCODE_BITS       = 6'h08;
	localparam logic [5:0] ADDR_BITS         = 6'h18;
	localparam logic [5:0] DUMMY_BITS        = 6'h08;
	localparam logic [3:0] BYTE_BITS         = 4'h8;
	localparam logic [7:0] BLANK_BYTE        = 8'hFF;

	// Write-class opcodes need the write access delay
	function automatic logic is_write_cmd(input logic [7:0] op);
		unique case (op)
			8'h06, 8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h2F, 8'h01: is_write_cmd = 1'b1;
			default: is_write_cmd = 1'b0;
		endcase
	endfunction : is_write_cmd

endpackage : sft_pkg

// ---- hw/sft_param_table.sv ----
// Purpose: Serial parameter table responder with power-on gating and a Wishbone view
// Assumes: Link pins and supply monitors are asynchronous to clk_i; link mode 0
// Notes:   Link clock is oversampled; it must stay below about one eighth of clk_i
//
// Local design decisions: the register addresses and register access over Wishbone.

`timescale 1ns/1ns
`default_nettype none

module sft_param_table #(
	parameter int          SETTLE_CYC       = sft_pkg::SETTLE_CYC,
	parameter int          WRITE_ACCESS_CYC = sft_pkg::WRITE_ACCESS_CYC,
	parameter logic [31:0] DENSITY          = 32'h01FF_FFFF,
	parameter logic [7:0]  VENDOR_ID        = 8'hA5       // Arbitrary value
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Supply monitors
	input  wire logic        above_lockout_i,
	input  wire logic        supply_at_min_i,
	// Serial link
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic [3:0]  io_i,
	output logic      [3:0]  io_o,
	output logic      [3:0]  io_oe_o,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	// Elaboration checks
	if (SETTLE_CYC < 1 || WRITE_ACCESS_CYC < 1) begin : g_chk
		$error("sft_param_table: delay counts must be at least one cycle");
	end

	typedef enum logic [2:0] {
		SFT_IDLE   = 3'b000,
		SFT_OPCODE = 3'b001,
		SFT_ADDR   = 3'b010,
		SFT_DUMMY  = 3'b011,
		SFT_DATA   = 3'b100,
		SFT_SKIP   = 3'b101
	} sft_state_t;

	typedef struct packed {
		logic [1:0]  sclk_sync;
		logic        sclk_prev;
		logic [1:0]  cs_sync;
		logic [7:0]  io_sync;
		logic [1:0]  lock_sync;
		logic [1:0]  min_sync;
		logic [31:0] settle_cnt;
		logic [31:0] wacc_cnt;
		logic        reads_ok;
		logic        writes_ok;
		logic        write_permit_latch;
		logic        deep_pd;
		logic        refused;
		logic [1:0]  width;
		sft_state_t  state;
		logic [5:0]  bit_cnt;
		logic [7:0]  opcode;
		logic [23:0] taddr;
		logic [7:0]  out_sh;
		logic [3:0]  out_left;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic [31:0] wb_dat;
		logic        wb_ack;
	} sft_regs_t;

	sft_regs_t r_ff;
	sft_regs_t nxt_r;

	// Parameter table image; density and vendor code come from the parameters
	function automatic logic [7:0] table_byte(input logic [23:0] a);
		table_byte = sft_pkg::BLANK_BYTE; // RL12
		if (a[23:8] == 16'h0000) begin
			unique case (a[7:0])
				8'h00: table_byte = 8'h53;
				8'h01: table_byte = 8'h46;
				8'h02: table_byte = 8'h44;
				8'h03: table_byte = 8'h50;
				8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16: table_byte = 8'h00; // RL4
				8'h05, 8'h06, 8'h0A, 8'h12: table_byte = 8'h01; // RL3
				8'h0B: table_byte = 8'h09; // RL4
				8'h0C: table_byte = 8'h30; // RL4
				8'h10: table_byte = VENDOR_ID;
				8'h13: table_byte = 8'h04; // RL5
				8'h14: table_byte = 8'h60; // RL5
				8'h30: table_byte = 8'hE5; // RL6
				8'h31: table_byte = 8'h20; // RL6
				8'h32: table_byte = 8'hB0; // RL7
				8'h34: table_byte = DENSITY[7:0];
				8'h35: table_byte = DENSITY[15:8];
				8'h36: table_byte = DENSITY[23:16];
				8'h37: table_byte = DENSITY[31:24];
				8'h38: table_byte = 8'h44; // RL8
				8'h39: table_byte = 8'hEB; // RL8
				8'h3A, 8'h3C, 8'h46: table_byte = 8'h00;
				8'h3E: table_byte = 8'h04; // RL9
				8'h3F: table_byte = 8'hBB; // RL9
				8'h40: table_byte = 8'hFE; // RL10
				8'h4A: table_byte = 8'h44; // RL10
				8'h4B: table_byte = 8'hEB; // RL10
				8'h4C: table_byte = 8'h0C; // RL11
				8'h4D: table_byte = 8'h20; // RL11
				8'h4E: table_byte = 8'h0F; // RL11
				8'h4F: table_byte = 8'h52; // RL11
				8'h50: table_byte = 8'h10; // RL11
				8'h51: table_byte = 8'hD8; // RL11
				8'h52: table_byte = 8'h00; // RL11
				8'h60: table_byte = 8'h00; // RL13
				8'h61: table_byte = 8'h20; // RL13
				8'h62: table_byte = 8'h50; // RL13
				8'h63: table_byte = 8'h16; // RL13
				8'h64: table_byte = 8'h9C; // RL14
				8'h65: table_byte = 8'hF9; // RL14
				8'h66: table_byte = 8'hC0; // RL15
				8'h67: table_byte = 8'h64; // RL15
				8'h68: table_byte = 8'hD9; // RL16
				8'h69: table_byte = 8'hC8; // RL16
				default: table_byte = sft_pkg::BLANK_BYTE; // RL12
			endcase
		end
	endfunction : table_byte

	// Bits moved per link edge for a width code
	function automatic logic [3:0] lane_bits(input logic [1:0] w);
		unique case (w)
			sft_pkg::SFT_W2: lane_bits = 4'h2;
			sft_pkg::SFT_W4: lane_bits = 4'h4;
			default:         lane_bits = 4'h1;
		endcase
	endfunction : lane_bits

	// Shift sampled input lanes into a byte, MSB first
	function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic [3:0] pins, input logic [1:0] w);
		unique case (w)
			sft_pkg::SFT_W2: shift_in = {cur[5:0], pins[1:0]};
			sft_pkg::SFT_W4: shift_in = {cur[3:0], pins};
			default:         shift_in = {cur[6:0], pins[0]};
		endcase
	endfunction : shift_in

	// Top bits of an output byte placed on the active lanes
	function automatic logic [3:0] lane_out(input logic [7:0] sh, input logic [1:0] w);
		unique case (w)
			sft_pkg::SFT_W2: lane_out = {2'b00, sh[7:6]};
			sft_pkg::SFT_W4: lane_out = sh[7:4];
			default:         lane_out = {2'b00, sh[7], 1'b0};
		endcase
	endfunction : lane_out

	// Lanes the device drives in a given width
	function automatic logic [3:0] lane_en(input logic [1:0] w);
		unique case (w)
			sft_pkg::SFT_W2: lane_en = 4'b0011;
			sft_pkg::SFT_W4: lane_en = 4'b1111;
			default:         lane_en = 4'b0010;
		endcase
	endfunction : lane_en

	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_active;
	logic [3:0] pins;
	logic [3:0] step;
	logic       wb_req;
	logic [7:0] in_byte;
	logic       refuse_set;

	// Link edge detection after the synchronisers
	assign sclk_rise = r_ff.sclk_sync[1] & ~r_ff.sclk_prev;
	assign sclk_fall = ~r_ff.sclk_sync[1] & r_ff.sclk_prev;
	assign cs_active = ~r_ff.cs_sync[1];
	assign pins      = r_ff.io_sync[7:4];
	assign step      = lane_bits(r_ff.width);
	assign wb_req    = wb_cyc_i & wb_stb_i & ~r_ff.wb_ack;
	assign in_byte   = shift_in(r_ff.opcode, pins, r_ff.width);

	// Next-state logic
	always_comb begin
		nxt_r = r_ff;
		refuse_set = 1'b0;

		// Two-stage synchronisers; only stage two is read
		nxt_r.sclk_sync = {r_ff.sclk_sync[0], sclk_i};
		nxt_r.sclk_prev = r_ff.sclk_sync[1];
		nxt_r.cs_sync   = {r_ff.cs_sync[0], cs_n_i};
		nxt_r.io_sync   = {r_ff.io_sync[3:0], io_i};
		nxt_r.lock_sync = {r_ff.lock_sync[0], above_lockout_i};
		nxt_r.min_sync  = {r_ff.min_sync[0], supply_at_min_i};

		// Power-on delays
		if (!r_ff.min_sync[1]) begin
			nxt_r.settle_cnt = '0;
			nxt_r.reads_ok   = 1'b0;
		end else if (r_ff.settle_cnt >= SETTLE_CYC - 1) begin
			nxt_r.reads_ok = 1'b1; // RL20
		end else begin
			nxt_r.settle_cnt = r_ff.settle_cnt + 32'h0000_0001;
		end
		if (r_ff.wacc_cnt < WRITE_ACCESS_CYC) begin
			nxt_r.wacc_cnt = r_ff.wacc_cnt + 32'h0000_0001;
		end
		nxt_r.writes_ok = r_ff.reads_ok & (r_ff.wacc_cnt >= WRITE_ACCESS_CYC); // RL19

		// Link frame handling
		if (!cs_active) begin
			nxt_r.state = SFT_IDLE; // RL1
			nxt_r.io_oe = 4'h0;
		end else begin
			unique case (r_ff.state)
				SFT_IDLE: begin
					nxt_r.bit_cnt  = '0;
					nxt_r.opcode   = '0;
					nxt_r.state    = r_ff.reads_ok ? SFT_OPCODE : SFT_SKIP; // RL20
				end
				SFT_OPCODE: begin
					if (sclk_rise) begin
						nxt_r.opcode  = in_byte;
						nxt_r.bit_cnt = r_ff.bit_cnt + {2'b00, step};
						if (r_ff.bit_cnt + {2'b00, step} == sft_pkg::OPCODE_BITS) begin
							nxt_r.bit_cnt = '0;
							nxt_r.state   = SFT_SKIP;
							if (r_ff.deep_pd) begin
								if (in_byte == sft_pkg::OP_RELEASE_PD) begin
									nxt_r.deep_pd = 1'b0;
								end
							end else if (in_byte == sft_pkg::OP_PARAM_READ) begin
								nxt_r.state = SFT_ADDR; // RL2
							end else if (sft_pkg::is_write_cmd(in_byte) && !r_ff.writes_ok) begin
								nxt_r.refused = 1'b1; // RL19
								refuse_set    = 1'b1;
							end else if (in_byte == sft_pkg::OP_WRITE_ENABLE) begin
								nxt_r.write_permit_latch = 1'b1;
							end else if (in_byte == sft_pkg::OP_WRITE_DISABLE) begin
								nxt_r.write_permit_latch = 1'b0;
							end else if (in_byte == sft_pkg::OP_DEEP_PD) begin
								nxt_r.deep_pd = 1'b1;
							end
						end
					end
				end
				SFT_ADDR: begin
					if (sclk_rise) begin
						unique case (r_ff.width)
							sft_pkg::SFT_W2: nxt_r.taddr = {r_ff.taddr[21:0], pins[1:0]};
							sft_pkg::SFT_W4: nxt_r.taddr = {r_ff.taddr[19:0], pins};
							default:         nxt_r.taddr = {r_ff.taddr[22:0], pins[0]};
						endcase
						nxt_r.bit_cnt = r_ff.bit_cnt + {2'b00, step};
						if (r_ff.bit_cnt + {2'b00, step} == sft_pkg::ADDR_BITS) begin
							nxt_r.bit_cnt = '0;
							nxt_r.state   = SFT_DUMMY; // RL1
						end
					end
				end
				SFT_DUMMY: begin
					if (sclk_rise) begin
						nxt_r.bit_cnt = r_ff.bit_cnt + {2'b00, step};
						if (r_ff.bit_cnt + {2'b00, step} == sft_pkg::DUMMY_BITS) begin
							nxt_r.state    = SFT_DATA;
							nxt_r.out_left = '0;
						end
					end
				end
				SFT_DATA: begin
					// Drive on the falling link edge, host samples on the rising one
					if (sclk_fall) begin
						if (r_ff.out_left == 4'h0) begin
							nxt_r.out_sh   = table_byte(r_ff.taddr) << step;
							nxt_r.io_out   = lane_out(table_byte(r_ff.taddr), r_ff.width);
							nxt_r.taddr    = r_ff.taddr + 24'h00_0001; // RL21
							nxt_r.out_left = sft_pkg::BYTE_BITS - step;
						end else begin
							nxt_r.io_out   = lane_out(r_ff.out_sh, r_ff.width);
							nxt_r.out_sh   = r_ff.out_sh << step;
							nxt_r.out_left = r_ff.out_left - step;
						end
						nxt_r.io_oe = lane_en(r_ff.width);
					end
				end
				SFT_SKIP: begin
					nxt_r.state = SFT_SKIP;
				end
				default: begin
					nxt_r.state = SFT_IDLE;
				end
			endcase
		end

		// Wishbone slave: one-cycle ack, unmapped reads give zero
		nxt_r.wb_ack = wb_req;
		if (wb_req) begin
			nxt_r.wb_dat = '0;
			unique case (wb_adr_i)
				sft_pkg::REG_CTRL_ADR: begin
					nxt_r.wb_dat[sft_pkg::CTRL_WIDTH_LSB +: 2] = r_ff.width;
					if (wb_we_i && wb_sel_i[0] && wb_dat_i[sft_pkg::CTRL_WIDTH_LSB +: 2] != 2'b11) begin
						nxt_r.width = wb_dat_i[sft_pkg::CTRL_WIDTH_LSB +: 2]; // RL2
					end
				end
				sft_pkg::REG_STATUS_ADR: begin
					nxt_r.wb_dat[sft_pkg::ST_ABOVE_LOCKOUT] = r_ff.lock_sync[1];
					nxt_r.wb_dat[sft_pkg::ST_READS_OK]      = r_ff.reads_ok;
					nxt_r.wb_dat[sft_pkg::ST_WRITES_OK]     = r_ff.writes_ok;
					nxt_r.wb_dat[sft_pkg::ST_WRITE_PERMIT]  = r_ff.write_permit_latch;
					nxt_r.wb_dat[sft_pkg::ST_DEEP_PD]       = r_ff.deep_pd;
					nxt_r.wb_dat[sft_pkg::ST_REFUSED]       = r_ff.refused;
					// Write one clears; a refusal in the same cycle wins
					if (wb_we_i && wb_sel_i[0] && wb_dat_i[sft_pkg::ST_REFUSED] && !refuse_set) begin
						nxt_r.refused = 1'b0;
					end
				end
				sft_pkg::REG_TADDR_ADR: begin
					nxt_r.wb_dat[23:0] = r_ff.taddr;
				end
				default: begin
					nxt_r.wb_dat = '0;
				end
			endcase
		end

		// Below the lockout threshold the delays, latches and link frame rest; the synchronisers and the Wishbone slave run on
		if (!r_ff.lock_sync[1]) begin
			nxt_r.settle_cnt         = '0;
			nxt_r.wacc_cnt           = '0;
			nxt_r.reads_ok           = 1'b0; // RL18
			nxt_r.writes_ok          = 1'b0;
			nxt_r.write_permit_latch = 1'b0; // RL17
			nxt_r.deep_pd            = 1'b0; // RL17
			nxt_r.state              = cs_active ? SFT_SKIP : SFT_IDLE; // RL18
			nxt_r.io_oe              = 4'h0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_ff       <= '0;
			r_ff.width <= sft_pkg::CTRL_WIDTH_RST;
			r_ff.state <= SFT_IDLE;
			r_ff.cs_sync <= 2'b11;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs from flip-flops
	assign io_o     = r_ff.io_out;
	assign io_oe_o  = r_ff.io_oe;
	assign wb_dat_o = r_ff.wb_dat;
	assign wb_ack_o = r_ff.wb_ack;

endmodule : sft_param_table

`default_nettype wire

// ---- bench/sft_param_table_sva.sv ----
// Purpose: Port-level checks for the parameter table block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module sft_param_table_sva #(
	parameter int SETTLE_CYC = 20
) (
	// Clock, reset and supply monitors
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        above_lockout_i,
	input wire logic        supply_at_min_i,
	// Link
	input wire logic        sclk_i,
	input wire logic        cs_n_i,
	input wire logic [3:0]  io_o,
	input wire logic [3:0]  io_oe_o,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	logic [31:0] settle_cnt_ff;
	logic [31:0] nxt_settle_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Cycles since both supply monitors went high, saturating
	always_comb begin
		nxt_settle_cnt = settle_cnt_ff;
		if (!(above_lockout_i && supply_at_min_i))
			nxt_settle_cnt = 32'h0000_0000;
		else if (settle_cnt_ff < 32'(SETTLE_CYC))
			nxt_settle_cnt = settle_cnt_ff + 32'h0000_0001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			settle_cnt_ff <= 32'h0000_0000;
		else
			settle_cnt_ff <= nxt_settle_cnt;
	end
	// Power and link gating
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> io_oe_o == 4'h0 && !wb_ack_o && wb_dat_o == 32'h0000_0000) else $error("Not quiet after reset");
	a_lockout_silent: assert property (!above_lockout_i [*6] |-> io_oe_o == 4'h0)
		else $error("Drives link below lockout");
	a_settle_gate: assert property (settle_cnt_ff < 32'(SETTLE_CYC) |-> io_oe_o == 4'h0)
		else $error("Drives link before settle delay");
	a_lane_set: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("Illegal lane enable pattern");
	a_cs_release: assert property (cs_n_i [*8] |-> io_oe_o == 4'h0)
		else $error("Drives link while deselected");
	a_lane_hold: assert property ($rose(sclk_i) |=> $stable(io_o) [*4])
		else $error("Lane changed while link clock high");
	// Wishbone handshake
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("No acknowledge one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("Acknowledge without request");
endmodule : sft_param_table_sva
bind sft_param_table sft_param_table_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.above_lockout_i(above_lockout_i), .supply_at_min_i(supply_at_min_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
	.io_o(io_o), .io_oe_o(io_oe_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ---- bench/sft_host_model.sv ----
// Purpose: Host serial controller model issuing link frames
// Assumes: Link mode 0, 48 ns link clock, idle low outside frames
// Notes:   Lanes the host releases show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module sft_host_model (
	// Link pins driven by the host
	output logic            sclk_o,
	output logic            cs_n_o,
	output logic      [3:0] io_o,
	// Resolved lanes
	input  wire logic [3:0] io_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o   = 4'h0;
	end
	// One byte out, MSB first, w lanes per clock, high lane most significant
	task automatic send(input logic [7:0] v, input int w);
		for (int i = 8 - w; i >= 0; i -= w) begin
			io_o = ~io_o;
			for (int k = 0; k < w; k++)
				io_o[k] = v[i + k];
			#24 sclk_o = 1'b1;
			#24 sclk_o = 1'b0;
		end
	endtask : send
	// One byte in, sampled at each rising link edge
	task automatic recv(input int w, output logic [7:0] b);
		b = 8'h00;
		for (int i = 0; i < 8; i += w) begin
			io_o = ~io_o;
			#24 sclk_o = 1'b1;
			if (w == 1)
				b = {b[6:0], io_i[1]};
			for (int k = w - 1; k >= 0 && w > 1; k--)
				b = {b[6:0], io_i[k]};
			#24 sclk_o = 1'b0;
		end
	endtask : recv
	// Opcode alone when n is zero, else address, dummy byte and n data bytes
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int w, n, output logic [31:0] q);
		logic [7:0] b;
		q = 32'h0000_0000;
		// Step off the core clock edges so no link pin moves on a sampling edge
		#1 cs_n_o = 1'b0;
		send(op, w);
		if (n > 0) begin
			send(a[23:16], w);
			send(a[15:8], w);
			send(a[7:0], w);
			send(8'h00, w);
		end
		for (int j = 0; j < n; j++) begin
			recv(w, b);
			q = {q[23:0], b};
		end
		#8 cs_n_o = 1'b1;
		io_o = ~io_o;
		#40;
	endtask : frame
endmodule : sft_host_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the parameter table block
// Assumes: 250 MHz clock, host model drives the link at 48 ns
// Notes:   Short settle and write access counts keep the run brief
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {
		logic [1:0]  w;
		logic [7:0]  a;
		logic [31:0] e;
	} sft_row_t;
	// Width code, start address and four bytes in read order
	localparam sft_row_t ROWS [18] = '{
		'{2'h0, 8'h04, 32'h0001_01FF}, '{2'h1, 8'h08, 32'h0000_0109}, '{2'h2, 8'h0C, 32'h3000_00FF},
		'{2'h0, 8'h11, 32'h0001_0460}, '{2'h1, 8'h30, 32'hE520_B0FF}, '{2'h2, 8'h38, 32'h44EB_00FF},
		'{2'h0, 8'h3C, 32'h00FF_04BB}, '{2'h1, 8'h40, 32'hFEFF_FFFF}, '{2'h2, 8'h4A, 32'h44EB_0C20},
		'{2'h0, 8'h4E, 32'h0F52_10D8}, '{2'h1, 8'h52, 32'h00FF_FFFF}, '{2'h2, 8'h60, 32'h0020_5016},
		'{2'h0, 8'h00, 32'h5346_4450}, '{2'h1, 8'h10, 32'h3C00_0104}, '{2'h2, 8'h34, 32'hFFFF_FF01},
		'{2'h0, 8'h64, 32'h9CF9_C064}, '{2'h1, 8'h68, 32'hD9C8_FFFF}, '{2'h2, 8'h6E, 32'hFFFF_FFFF}
	};
	logic        clk_i;
	logic        rst, ab_lock, sup_min, sclk, cs_n;
	logic        wb_cyc, wb_stb, wb_we, wb_ack;
	logic [3:0]  wb_adr, io_host, io_dev, io_oe, io_lane;
	logic [31:0] wb_dat, wb_rd, q, seen_oe;
	int          fails, cmp_count, cyc_cnt;
	// Lane level from both parties
	assign io_lane = (io_oe & io_dev) | (~io_oe & io_host);
	sft_param_table #(.SETTLE_CYC(20), .WRITE_ACCESS_CYC(200), .VENDOR_ID(8'h3C)) DUT (
		.clk_i(clk_i), .rst_i(rst), .above_lockout_i(ab_lock), .supply_at_min_i(sup_min),
		.sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_lane), .io_o(io_dev), .io_oe_o(io_oe),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack)
	);
	sft_host_model HOST (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_host), .io_i(io_lane));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Notes any cycle in which the device drives a lane, and cuts a hang short
	always @(posedge clk_i) begin
		if (io_oe !== 4'h0)
			seen_oe <= 32'h0000_0001;
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 50000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Classic single Wishbone cycle, held until acknowledge
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		r = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic wait_bit(input int k);
		do wb(1'b0, 4'h4, 32'h0000_0000, q); while (q[k] !== 1'b1);
	endtask : wait_bit
	// Link command, then status compared
	task automatic op_st(input logic [7:0] op, input int w, input logic [31:0] e);
		HOST.frame(op, 24'h00_0000, w, 0, q);
		wb(1'b0, 4'h4, 32'h0000_0000, q);
		chk(q, e);
	endtask : op_st
	initial begin
		{rst, ab_lock, sup_min, wb_cyc, wb_stb, wb_we} = 6'h20;
		{wb_adr, wb_dat, seen_oe, fails, cmp_count, cyc_cnt} = '0;
		repeat (4) @(posedge clk_i);
		rst <= 1'b0;
		wb(1'b0, 4'h4, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		HOST.frame(8'h5A, 24'h00_0010, 1, 2, q);
		chk(seen_oe, 32'h0000_0000);
		@(posedge clk_i);
		ab_lock <= 1'b1;
		sup_min <= 1'b1;
		wait_bit(1);
		chk(q, 32'h0000_0003);
		op_st(8'h06, 1, 32'h0000_0023);
		wait_bit(2);
		wb(1'b1, 4'h4, 32'h0000_0020, q);
		op_st(8'h06, 1, 32'h0000_000F);
		op_st(8'h04, 1, 32'h0000_0007);
		foreach (ROWS[i]) begin
			wb(1'b1, 4'h0, {30'h0, ROWS[i].w}, q);
			HOST.frame(8'h5A, {16'h0000, ROWS[i].a}, 1 << ROWS[i].w, 4, q);
			chk(q, ROWS[i].e);
			wb(1'b0, 4'h8, 32'h0000_0000, q);
			// The last link fall has already loaded the byte after the four read
			chk(q, {24'h00_0000, ROWS[i].a} + 32'h0000_0005);
		end
		wb(1'b1, 4'h0, 32'h0000_0003, q);
		wb(1'b0, 4'h0, 32'h0000_0000, q);
		chk(q, 32'h0000_0002);
		wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
		wb(1'b0, 4'hC, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		op_st(8'hB9, 4, 32'h0000_0017);
		seen_oe = 32'h0000_0000;
		HOST.frame(8'h5A, 24'h00_0030, 4, 2, q);
		chk(seen_oe, 32'h0000_0000);
		op_st(8'hAB, 4, 32'h0000_0007);
		op_st(8'h06, 4, 32'h0000_000F);
		@(posedge clk_i);
		ab_lock <= 1'b0;
		repeat (8) @(posedge clk_i);
		wb(1'b0, 4'h4, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		@(posedge clk_i);
		ab_lock <= 1'b1;
		wait_bit(1);
		chk(q, 32'h0000_0003);
		@(posedge clk_i);
		rst <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst <= 1'b0;
		wb(1'b0, 4'h0, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
